/* design/cfg_port_pkg.sv */
// Shared constants and types for the configuration port and start-up sequencer.
package cfg_port_pkg;
   // ======================================================================
   // Timing.
   localparam int    CLK_PERIOD_PS     = 10000;
   localparam int    INIT_LOW_TIME_NS  = 50000;
   localparam int    INIT_LOW_CYC      = (INIT_LOW_TIME_NS * 1000 + CLK_PERIOD_PS - 1)
                                         / CLK_PERIOD_PS;
   localparam int    TIMER_W           = 16;
   // ======================================================================
   // Widths, encodings and instruction codes.
   localparam int    IR_W              = 8;
   localparam int    BYTE_W            = 8;
   localparam int    BUF_DEPTH         = 2;
   localparam int    CNT_W             = 4;
   localparam logic [CNT_W-1:0] BYTE_BITS = 4'h8;
   localparam logic [IR_W-1:0]  IR_LOAD      = 8'h3A;
   localparam logic [IR_W-1:0]  IR_CAPTURE   = 8'h01;
   localparam logic [1:0]       WIDTH_SINGLE = 2'h0;
   localparam logic [1:0]       WIDTH_DUAL   = 2'h1;
   localparam logic [1:0]       WIDTH_QUAD   = 2'h2;
   // Bit positions of the shared pins in the hand-over vector.
   localparam int    PIN_CLK = 0;
   localparam int    PIN_SEL = 1;
   localparam int    PIN_D0  = 2;
   localparam int    PIN_D1  = 3;
   localparam int    PIN_D2  = 4;
   localparam int    PIN_D3  = 5;
   localparam int    NPINS   = 6;
   // ======================================================================
   // Types.
   typedef enum logic [1:0] {CTL_INIT = 2'h0, CTL_CONFIG = 2'h1, CTL_USER = 2'h3} ctl_state_t;
   typedef enum logic [3:0] {
      TAP_RESET = 4'h0, TAP_IDLE = 4'h1, TAP_SEL_DR = 4'h3, TAP_CAP_DR = 4'h2,
      TAP_SH_DR = 4'h6, TAP_EX1_DR = 4'h7, TAP_PAU_DR = 4'h5, TAP_EX2_DR = 4'h4,
      TAP_UPD_DR = 4'hC, TAP_SEL_IR = 4'hD, TAP_CAP_IR = 4'hF, TAP_SH_IR = 4'hE,
      TAP_EX1_IR = 4'hA, TAP_PAU_IR = 4'hB, TAP_EX2_IR = 4'h9, TAP_UPD_IR = 4'h8
   } tap_state_t;
   typedef struct packed {
      logic prog_n;
      logic init_line;
      logic d3;
      logic d2;
      logic d1;
      logic d0;
      logic tdi_sel;
      logic tms_sel;
      logic tck_clk;
   } pin_in_t;
   localparam int    PIN_IN_W = $bits(pin_in_t);
   typedef struct packed {
      logic       spi_en;
      logic [1:0] spi_width;
      logic       i2c_en;
   } keep_bits_t;
endpackage

/* design/cfg_port_init_sequencer.sv */
// Shared configuration pins, JTAG TAP, slave SPI receiver and start-up sequencer.
//
// Contract
// [RULE1] Capture on test-clock rise, output on fall.
// [RULE2] TAP state holds while test clock stops.
// [RULE3] TMS sampled on rise steps TAP.
// [RULE4] TDO driven only in Shift-IR/Shift-DR.
// [RULE5] SPI mode: test clock is SPI clock.
// [RULE6] SPI mode: test-mode pin is select, low.
// [RULE7] spi_data0 is serial input, bit 0.
// [RULE8] spi_data1 is serial output, bit 1.
// [RULE9] Quad mode: spi_data2/3 are bits 2/3.
// [RULE10] I2C mode: data2 clock, data3 data.
// [RULE11] Keep bits decide ports kept in user mode.
// [RULE12] Kept SPI keeps pins; quad adds data2/3.
// [RULE13] Kept I2C keeps clock and data lines.
// [RULE14] JTAG in user mode follows enable pin.
// [RULE15] Power-on reset holds all pins high-Z.
// [RULE16] After reset drive init and done low.
// [RULE17] Both low means initialization state.
// [RULE18] Initialization clears configuration memory.
// [RULE19] Leave init after timer, request, line high.
// [RULE20] Before configuration, GPIO tri-stated, pulled down.
// [RULE21] Unused GPIO stay tri-stated, pulled down.
// [RULE22] Init line released high enters configuration.
// [RULE23] Program request low restarts at initialization.
// [RULE24] Init timer is parameter, starts on entry.
`timescale 1ns/1ps
`default_nettype none
module cfg_port_init_sequencer #(
   parameter int INIT_LOW_CYC = cfg_port_pkg::INIT_LOW_CYC
) (
   input  wire logic                    sys_clk,
   input  wire logic                    rstn,
   input  wire logic                    jtag_port_enable,
   input  wire logic                    i2c_mode_sel,
   input  wire logic [1:0]              spi_bus_width,
   input  wire cfg_port_pkg::keep_bits_t port_keep_bits,
   input  wire logic                    cfg_complete,
   input  wire logic                    program_request_n,
   input  wire logic                    tck_sclk_in,
   input  wire logic                    tms_select_in,
   input  wire logic                    tdi_data0_in,
   input  wire logic                    spi_data1_in,
   output logic                         spi_data1_out,
   output logic                         spi_data1_oe,
   input  wire logic                    spi_data2_in,
   output logic                         spi_data2_oe,
   input  wire logic                    spi_data3_in,
   output logic                         spi_data3_oe,
   input  wire logic                    init_status_in,
   output logic                         init_status_out,
   output logic                         init_status_oe,
   input  wire logic                    done_in,
   output logic                         done_out,
   output logic                         done_oe,
   input  wire logic [7:0]              spi_read_byte,
   output logic [7:0]                   cfg_byte_data,
   output logic                         cfg_byte_valid,
   input  wire logic                    cfg_byte_ready,
   output logic                         cfg_buf_ready,
   output logic                         cfg_mem_clear,
   output logic                         gpio_tristate,
   output logic                         gpio_pulldown,
   output logic [cfg_port_pkg::NPINS-1:0] pins_to_user,
   output logic                         i2c_port_active,
   output logic                         user_mode
);
   // ======================================================================
   // Pin synchronisers: three stages, a change counts when stages 2 and 3 agree.
   cfg_port_pkg::pin_in_t pin_raw;
   logic [cfg_port_pkg::PIN_IN_W-1:0] s1_reg, s2_reg, s3_reg, stab_reg, prev_reg;
   cfg_port_pkg::pin_in_t pin, pin_prev;
   // The test clock idles low, so its stages reset low; resetting them high would fake an edge.
   localparam logic [cfg_port_pkg::PIN_IN_W-1:0] SYNC_RST = ~cfg_port_pkg::PIN_IN_W'(1);
   assign pin_raw = '{prog_n: program_request_n, init_line: init_status_in, d3: spi_data3_in,
                      d2: spi_data2_in, d1: spi_data1_in, d0: tdi_data0_in,
                      tdi_sel: tdi_data0_in, tms_sel: tms_select_in, tck_clk: tck_sclk_in};
   genvar gi;
   generate
      for (gi = 0; gi < cfg_port_pkg::PIN_IN_W; gi++)
      begin : g_sync
         always_ff @(posedge sys_clk or negedge rstn)
         begin
            if (!rstn)
            begin
               s1_reg[gi]   <= SYNC_RST[gi];
               s2_reg[gi]   <= SYNC_RST[gi];
               s3_reg[gi]   <= SYNC_RST[gi];
               stab_reg[gi] <= SYNC_RST[gi];
               prev_reg[gi] <= SYNC_RST[gi];
            end
            else
            begin
               s1_reg[gi]   <= pin_raw[gi];
               s2_reg[gi]   <= s1_reg[gi];
               s3_reg[gi]   <= s2_reg[gi];
               stab_reg[gi] <= (s2_reg[gi] == s3_reg[gi]) ? s3_reg[gi] : stab_reg[gi];
               prev_reg[gi] <= stab_reg[gi];
            end
         end
      end
   endgenerate
   assign pin      = cfg_port_pkg::pin_in_t'(stab_reg);
   assign pin_prev = cfg_port_pkg::pin_in_t'(prev_reg);
   wire clk_rise = pin.tck_clk & ~pin_prev.tck_clk;
   wire clk_fall = ~pin.tck_clk & pin_prev.tck_clk;

   // ======================================================================
   // Start-up sequencer.
   cfg_port_pkg::ctl_state_t    ctl_reg, ctl_next;
   logic [cfg_port_pkg::TIMER_W-1:0] timer_reg;
   logic                         init_drive_reg, done_drive_reg;
   cfg_port_pkg::keep_bits_t     keep_reg;
   wire timer_done = (timer_reg == cfg_port_pkg::TIMER_W'(INIT_LOW_CYC - 1));
   wire init_ready = timer_done & pin.prog_n;
   always_comb
   begin
      ctl_next = ctl_reg;
      case (ctl_reg)
         cfg_port_pkg::CTL_INIT:
            if (init_ready && !init_drive_reg && pin.init_line)
               ctl_next = cfg_port_pkg::CTL_CONFIG;     // [RULE19] [RULE22]
         cfg_port_pkg::CTL_CONFIG:
            if (cfg_complete)
               ctl_next = cfg_port_pkg::CTL_USER;
         cfg_port_pkg::CTL_USER:
            ctl_next = cfg_port_pkg::CTL_USER;
         default:
            ctl_next = cfg_port_pkg::CTL_INIT;
      endcase
      if (!pin.prog_n)
         ctl_next = cfg_port_pkg::CTL_INIT;            // [RULE23]
   end
   wire enter_init = (ctl_next == cfg_port_pkg::CTL_INIT) && (ctl_reg != cfg_port_pkg::CTL_INIT);
   // The power-on reset leaves every enable low, so all pins float while it is active.
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         ctl_reg        <= cfg_port_pkg::CTL_INIT;     // [RULE17]
         timer_reg      <= '0;
         init_drive_reg <= 1'b0;                       // [RULE15]
         done_drive_reg <= 1'b0;
         keep_reg       <= '0;
      end
      else
      begin
         ctl_reg        <= ctl_next;
         timer_reg      <= (enter_init || !pin.prog_n) ? '0 :
                           (ctl_reg == cfg_port_pkg::CTL_INIT && !timer_done) ?
                           timer_reg + 1'b1 : timer_reg;          // [RULE24]
         init_drive_reg <= (ctl_next == cfg_port_pkg::CTL_INIT) && !(init_ready && !enter_init);
         done_drive_reg <= (ctl_next != cfg_port_pkg::CTL_USER);  // [RULE16]
         keep_reg       <= (ctl_next == cfg_port_pkg::CTL_INIT) ? '0 :
                           (ctl_next == cfg_port_pkg::CTL_USER &&
                            ctl_reg == cfg_port_pkg::CTL_CONFIG) ? port_keep_bits : keep_reg;
      end
   end
   assign init_status_out = 1'b0;
   assign init_status_oe  = init_drive_reg;            // [RULE16]
   assign done_out        = 1'b0;
   assign done_oe         = done_drive_reg;
   assign cfg_mem_clear   = (ctl_reg == cfg_port_pkg::CTL_INIT);  // [RULE18]
   assign user_mode       = (ctl_reg == cfg_port_pkg::CTL_USER);
   // Without a user design inside this block every GPIO stays parked.
   assign gpio_tristate   = 1'b1;                      // [RULE20] [RULE21]
   assign gpio_pulldown   = 1'b1;

   // ======================================================================
   // Port selection.
   wire jtag_active = jtag_port_enable;                // [RULE14]
   wire i2c_active  = !jtag_active && (user_mode ? keep_reg.i2c_en : i2c_mode_sel); // [RULE13]
   wire spi_active  = !jtag_active && (user_mode ? keep_reg.spi_en : !i2c_mode_sel); // [RULE11]
   wire [1:0] width = user_mode ? keep_reg.spi_width : spi_bus_width;
   wire quad_active = spi_active && !i2c_active && (width == cfg_port_pkg::WIDTH_QUAD); // [RULE12]
   assign i2c_port_active = i2c_active;                // [RULE10]
   always_comb
   begin
      pins_to_user = '0;
      if (user_mode)
      begin
         pins_to_user[cfg_port_pkg::PIN_CLK] = !jtag_active && !spi_active;
         pins_to_user[cfg_port_pkg::PIN_SEL] = !jtag_active && !spi_active;
         pins_to_user[cfg_port_pkg::PIN_D0]  = !jtag_active && !spi_active;
         pins_to_user[cfg_port_pkg::PIN_D1]  = !jtag_active && !spi_active;
         pins_to_user[cfg_port_pkg::PIN_D2]  = !quad_active && !i2c_active;
         pins_to_user[cfg_port_pkg::PIN_D3]  = !quad_active && !i2c_active;
      end
   end

   // ======================================================================
   // JTAG TAP, stepped only by edges of the sampled test clock, so a stopped clock freezes it.
   function automatic cfg_port_pkg::tap_state_t tap_step(cfg_port_pkg::tap_state_t s,
                                                         logic tms);
      case (s)
         cfg_port_pkg::TAP_RESET:  tap_step = tms ? cfg_port_pkg::TAP_RESET  : cfg_port_pkg::TAP_IDLE;
         cfg_port_pkg::TAP_IDLE:   tap_step = tms ? cfg_port_pkg::TAP_SEL_DR : cfg_port_pkg::TAP_IDLE;
         cfg_port_pkg::TAP_SEL_DR: tap_step = tms ? cfg_port_pkg::TAP_SEL_IR : cfg_port_pkg::TAP_CAP_DR;
         cfg_port_pkg::TAP_CAP_DR: tap_step = tms ? cfg_port_pkg::TAP_EX1_DR : cfg_port_pkg::TAP_SH_DR;
         cfg_port_pkg::TAP_SH_DR:  tap_step = tms ? cfg_port_pkg::TAP_EX1_DR : cfg_port_pkg::TAP_SH_DR;
         cfg_port_pkg::TAP_EX1_DR: tap_step = tms ? cfg_port_pkg::TAP_UPD_DR : cfg_port_pkg::TAP_PAU_DR;
         cfg_port_pkg::TAP_PAU_DR: tap_step = tms ? cfg_port_pkg::TAP_EX2_DR : cfg_port_pkg::TAP_PAU_DR;
         cfg_port_pkg::TAP_EX2_DR: tap_step = tms ? cfg_port_pkg::TAP_UPD_DR : cfg_port_pkg::TAP_SH_DR;
         cfg_port_pkg::TAP_UPD_DR: tap_step = tms ? cfg_port_pkg::TAP_SEL_DR : cfg_port_pkg::TAP_IDLE;
         cfg_port_pkg::TAP_SEL_IR: tap_step = tms ? cfg_port_pkg::TAP_RESET  : cfg_port_pkg::TAP_CAP_IR;
         cfg_port_pkg::TAP_CAP_IR: tap_step = tms ? cfg_port_pkg::TAP_EX1_IR : cfg_port_pkg::TAP_SH_IR;
         cfg_port_pkg::TAP_SH_IR:  tap_step = tms ? cfg_port_pkg::TAP_EX1_IR : cfg_port_pkg::TAP_SH_IR;
         cfg_port_pkg::TAP_EX1_IR: tap_step = tms ? cfg_port_pkg::TAP_UPD_IR : cfg_port_pkg::TAP_PAU_IR;
         cfg_port_pkg::TAP_PAU_IR: tap_step = tms ? cfg_port_pkg::TAP_EX2_IR : cfg_port_pkg::TAP_PAU_IR;
         cfg_port_pkg::TAP_EX2_IR: tap_step = tms ? cfg_port_pkg::TAP_UPD_IR : cfg_port_pkg::TAP_SH_IR;
         cfg_port_pkg::TAP_UPD_IR: tap_step = tms ? cfg_port_pkg::TAP_SEL_DR : cfg_port_pkg::TAP_IDLE;
         default:                  tap_step = cfg_port_pkg::TAP_RESET;
      endcase
   endfunction
   cfg_port_pkg::tap_state_t          tap_reg;
   logic [cfg_port_pkg::IR_W-1:0]     ir_reg, ir_sh_reg;
   logic [cfg_port_pkg::BYTE_W-1:0]   dr_sh_reg;
   logic                              byp_reg, tdo_reg, tdo_oe_reg;
   wire tck_rise   = jtag_active & clk_rise;
   wire tck_fall   = jtag_active & clk_fall;
   wire in_shift   = (tap_reg == cfg_port_pkg::TAP_SH_IR) || (tap_reg == cfg_port_pkg::TAP_SH_DR);
   wire load_sel   = (ir_reg == cfg_port_pkg::IR_LOAD);
   wire jtag_push  = tck_rise && (tap_reg == cfg_port_pkg::TAP_UPD_DR) && load_sel;
   wire tdo_bit    = (tap_reg == cfg_port_pkg::TAP_SH_IR) ? ir_sh_reg[0] :
                     load_sel ? dr_sh_reg[0] : byp_reg;
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         tap_reg    <= cfg_port_pkg::TAP_RESET;
         ir_reg     <= '1;
         ir_sh_reg  <= '0;
         dr_sh_reg  <= '0;
         byp_reg    <= 1'b0;
         tdo_reg    <= 1'b0;
         tdo_oe_reg <= 1'b0;
      end
      else
      begin
         if (tck_rise)
         begin
            tap_reg <= tap_step(tap_reg, pin.tms_sel);                       // [RULE3]
            case (tap_reg)
               cfg_port_pkg::TAP_RESET:  ir_reg    <= '1;
               cfg_port_pkg::TAP_CAP_IR: ir_sh_reg <= cfg_port_pkg::IR_CAPTURE;
               cfg_port_pkg::TAP_SH_IR:  ir_sh_reg <= {pin.tdi_sel, ir_sh_reg[cfg_port_pkg::IR_W-1:1]}; // [RULE1]
               cfg_port_pkg::TAP_UPD_IR: ir_reg    <= ir_sh_reg;
               cfg_port_pkg::TAP_CAP_DR: byp_reg   <= 1'b0;
               cfg_port_pkg::TAP_SH_DR:
               begin
                  dr_sh_reg <= {pin.tdi_sel, dr_sh_reg[cfg_port_pkg::BYTE_W-1:1]}; // [RULE1]
                  byp_reg   <= pin.tdi_sel;
               end
               default:                  byp_reg   <= byp_reg;
            endcase
         end
         if (tck_fall)
         begin
            tdo_reg    <= tdo_bit;                                           // [RULE1]
            tdo_oe_reg <= in_shift;                                          // [RULE4]
         end
         if (!jtag_active)
            tdo_oe_reg <= 1'b0;
      end
   end

   // ======================================================================
   // Slave SPI: sampled clock, low-active select, one, two or four lanes.
   logic [cfg_port_pkg::BYTE_W-1:0] rx_sh_reg, tx_sh_reg;
   logic [cfg_port_pkg::CNT_W-1:0]  rx_cnt_reg;
   logic                            so_reg, so_oe_reg;
   wire sel_active = spi_active && !pin.tms_sel;                           // [RULE6]
   wire sclk_rise  = sel_active & clk_rise;                                // [RULE5]
   wire sclk_fall  = sel_active & clk_fall;
   wire sel_fall   = spi_active & !pin.tms_sel & pin_prev.tms_sel;
   wire single     = (width == cfg_port_pkg::WIDTH_SINGLE);
   wire [cfg_port_pkg::CNT_W-1:0] step = single ? 4'h1 :
                                         (width == cfg_port_pkg::WIDTH_DUAL) ? 4'h2 : 4'h4;
   wire [cfg_port_pkg::BYTE_W-1:0] rx_next =
        single ? {rx_sh_reg[6:0], pin.d0} :                                // [RULE7]
        (width == cfg_port_pkg::WIDTH_DUAL) ? {rx_sh_reg[5:0], pin.d1, pin.d0} : // [RULE8]
        {rx_sh_reg[3:0], pin.d3, pin.d2, pin.d1, pin.d0};                  // [RULE9]
   wire [cfg_port_pkg::CNT_W-1:0] cnt_next = rx_cnt_reg + step;
   wire spi_push = sclk_rise && (cnt_next == cfg_port_pkg::BYTE_BITS);
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         rx_sh_reg  <= '0;
         rx_cnt_reg <= '0;
         tx_sh_reg  <= '0;
         so_reg     <= 1'b0;
         so_oe_reg  <= 1'b0;
      end
      else
      begin
         if (!sel_active)
            rx_cnt_reg <= '0;
         else if (sclk_rise)
         begin
            rx_sh_reg  <= rx_next;
            rx_cnt_reg <= spi_push ? '0 : cnt_next;
         end
         if (sel_fall)
            tx_sh_reg <= spi_read_byte;
         else if (sclk_fall && single)
         begin
            so_reg    <= tx_sh_reg[cfg_port_pkg::BYTE_W-1];                // [RULE8]
            tx_sh_reg <= {tx_sh_reg[6:0], 1'b0};
         end
         so_oe_reg <= sel_active && single;
      end
   end
   assign spi_data1_out = jtag_active ? tdo_reg : so_reg;
   assign spi_data1_oe  = jtag_active ? tdo_oe_reg : so_oe_reg;            // [RULE4]
   // Read-back uses the single lane only; dual and quad lanes are always inputs.
   assign spi_data2_oe  = 1'b0;
   assign spi_data3_oe  = 1'b0;

   // ======================================================================
   // Two-entry buffer between the receivers and the configuration engine.
   logic [cfg_port_pkg::BYTE_W-1:0] buf_mem [cfg_port_pkg::BUF_DEPTH];
   logic                            wr_ptr_reg, rd_ptr_reg;
   logic [1:0]                      count_reg;
   wire push  = (jtag_push || spi_push) && cfg_buf_ready;
   wire pop   = cfg_byte_valid && cfg_byte_ready;
   wire [cfg_port_pkg::BYTE_W-1:0] push_data = jtag_push ? dr_sh_reg : rx_next;
   assign cfg_buf_ready  = (count_reg != 2'(cfg_port_pkg::BUF_DEPTH));
   assign cfg_byte_valid = (count_reg != 2'h0);
   assign cfg_byte_data  = buf_mem[rd_ptr_reg];
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         buf_mem[0] <= '0;
         buf_mem[1] <= '0;
         wr_ptr_reg <= 1'b0;
         rd_ptr_reg <= 1'b0;
         count_reg  <= 2'h0;
      end
      else
      begin
         if (push)
            buf_mem[wr_ptr_reg] <= push_data;
         wr_ptr_reg <= wr_ptr_reg ^ push;
         rd_ptr_reg <= rd_ptr_reg ^ pop;
         count_reg  <= count_reg + 2'(push) - 2'(pop);
      end
   end

   // ======================================================================
   // Checks.
   property p_tdo_hiz;
      @(posedge sys_clk) disable iff (!rstn)
      (tck_fall && !in_shift) |=> !spi_data1_oe;
   endproperty
   a_tdo_hiz: assert property (p_tdo_hiz) else $error("TDO driven outside shift states"); // [RULE4]
   property p_tap_tlr_hold;
      @(posedge sys_clk) disable iff (!rstn)
      (tck_rise && pin.tms_sel && tap_reg == cfg_port_pkg::TAP_RESET) |=>
      (tap_reg == cfg_port_pkg::TAP_RESET);
   endproperty
   a_tap_tlr_hold: assert property (p_tap_tlr_hold) else $error("TAP left reset with TMS high"); // [RULE3]
   property p_tap_static;
      @(posedge sys_clk) disable iff (!rstn)
      (!clk_rise) |=> $stable(tap_reg);
   endproperty
   a_tap_static: assert property (p_tap_static) else $error("TAP moved without clock edge"); // [RULE2]
   property p_init_drive;
      @(posedge sys_clk) disable iff (!rstn)
      (ctl_reg == cfg_port_pkg::CTL_INIT && !timer_done) ##1
      (ctl_reg == cfg_port_pkg::CTL_INIT) |-> init_status_oe && done_oe;
   endproperty
   a_init_drive: assert property (p_init_drive) else $error("init or done not driven low"); // [RULE16]
   property p_to_config;
      @(posedge sys_clk) disable iff (!rstn)
      (ctl_reg == cfg_port_pkg::CTL_INIT) ##1 (ctl_reg == cfg_port_pkg::CTL_CONFIG) |->
      $past(pin.init_line) && $past(pin.prog_n) && $past(timer_done);
   endproperty
   a_to_config: assert property (p_to_config) else $error("left init too early"); // [RULE19]
   property p_restart;
      @(posedge sys_clk) disable iff (!rstn)
      (!pin.prog_n && ctl_reg != cfg_port_pkg::CTL_INIT) |=>
      (ctl_reg == cfg_port_pkg::CTL_INIT) && (timer_reg == '0);
   endproperty
   a_restart: assert property (p_restart) else $error("program request did not restart"); // [RULE23]
   property p_clear;
      @(posedge sys_clk) disable iff (!rstn)
      (ctl_reg == cfg_port_pkg::CTL_INIT) |-> cfg_mem_clear && keep_reg == '0 ##1 1'b1;
   endproperty
   a_clear: assert property (p_clear) else $error("memory not cleared in init"); // [RULE18]
   property p_jtag_user;
      @(posedge sys_clk) disable iff (!rstn)
      user_mode |-> (pins_to_user[cfg_port_pkg::PIN_CLK] == (!jtag_port_enable && !spi_active));
   endproperty
   a_jtag_user: assert property (p_jtag_user) else $error("JTAG pin hand-over wrong"); // [RULE14]
   property p_quad_pins;
      @(posedge sys_clk) disable iff (!rstn)
      (user_mode && !keep_reg.i2c_en && !jtag_port_enable && keep_reg.spi_en &&
       keep_reg.spi_width == cfg_port_pkg::WIDTH_QUAD) |-> !pins_to_user[cfg_port_pkg::PIN_D2];
   endproperty
   a_quad_pins: assert property (p_quad_pins) else $error("quad pins released"); // [RULE12]
endmodule
`default_nettype wire

/* test/spi_host_model.sv */
// Host programmer model that drives the shared slave serial configuration pins.
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
   output logic sclk,
   output logic sel_n,
   output logic d0
);
   initial
   begin
      sclk  = 1'b0;
      sel_n = 1'b1;
      d0    = 1'b0;
   end
   // The clock stands still between frames; a released data line shows the inverse value.
   task automatic send_byte(input logic [7:0] b);
      sel_n = 1'b0;
      for (int i = 7; i >= 0; i--)
      begin
         d0 = b[i];
         #80 sclk = 1'b1;
         #80 sclk = 1'b0;
      end
      #80 sel_n = 1'b1;
      d0 = ~b[0];
      #80;
   endtask
endmodule
`default_nettype wire

/* test/config_port_init_sequencer_tb_top.sv */
// Self-checking bench for the configuration port start-up sequencer.
`timescale 1ns/1ps
`default_nettype none
module config_port_init_sequencer_tb_top;
   logic       sys_clk = 1'b0, rstn = 1'b0, prog_n = 1'b1, hold = 1'b1, done_c = 1'b0;
   logic       rdy = 1'b0, jen = 1'b0, isel = 1'b0;
   logic [1:0] width = 2'h0;
   logic [3:0] keep = 4'h0;
   logic       sck, sel_n, sd0, d1o, d1oe, d2oe, d3oe, ini_oe, dn_oe;
   logic       valid, bufrdy, clr, gtri, gpd, umode;
   logic [7:0] data, rb = 8'h00;
   logic [5:0] pins;
   int         n_fail = 0, checked = 0;
   // A second device on the wire-ANDed init line is stood in for by hold.
   wire        ini = ~(ini_oe | hold);
   always #5 sys_clk = ~sys_clk;
   always @(posedge sck) rb <= {rb[6:0], d1o};
   spi_host_model spi_host_model_inst (.sclk(sck), .sel_n(sel_n), .d0(sd0));
   cfg_port_init_sequencer #(.INIT_LOW_CYC(20)) cfg_port_init_sequencer_inst (
      .sys_clk(sys_clk), .rstn(rstn), .jtag_port_enable(jen), .i2c_mode_sel(isel),
      .spi_bus_width(width), .port_keep_bits(keep), .cfg_complete(done_c),
      .program_request_n(prog_n), .tck_sclk_in(sck), .tms_select_in(sel_n),
      .tdi_data0_in(sd0), .spi_data1_in(d1oe ? d1o : 1'b1), .spi_data1_out(d1o),
      .spi_data1_oe(d1oe), .spi_data2_in(jen), .spi_data2_oe(d2oe), .spi_data3_in(jen),
      .spi_data3_oe(d3oe), .init_status_in(ini), .init_status_out(), .init_status_oe(ini_oe),
      .done_in(~dn_oe), .done_out(), .done_oe(dn_oe), .spi_read_byte(8'h5A),
      .cfg_byte_data(data), .cfg_byte_valid(valid), .cfg_byte_ready(rdy),
      .cfg_buf_ready(bufrdy), .cfg_mem_clear(clr), .gpio_tristate(gtri),
      .gpio_pulldown(gpd), .pins_to_user(pins), .i2c_port_active(), .user_mode(umode));
   task automatic cyc(input int n);
      repeat (n) @(negedge sys_clk);
   endtask
   task automatic chk(input logic [11:0] got, input logic [11:0] exp);
      checked++;
      if (got !== exp)
      begin
         n_fail++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic results;
      $display("checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic t_reset;
      cyc(1);
      chk({ini_oe, dn_oe, d1oe, d2oe, d3oe}, 12'h000);
      chk({gtri, gpd, clr}, 12'h007);
      cyc(2);
      rstn = 1'b1;
      cyc(2);
      chk({ini_oe, dn_oe, clr, umode}, 12'h00E);
   endtask
   task automatic t_init;
      cyc(8);
      chk(ini_oe, 12'h001);
      cyc(40);
      chk({ini_oe, clr}, 12'h001);
      hold = 1'b0;
      cyc(8);
      chk({clr, umode}, 12'h000);
   endtask
   task automatic t_spi;
      spi_host_model_inst.send_byte(8'hA5);
      chk(rb[6:0], 12'h02D);
      spi_host_model_inst.send_byte(8'h3C);
      spi_host_model_inst.send_byte(8'hFF);
      cyc(4);
      chk({valid, bufrdy, data}, 12'h2A5);
      rdy = 1'b1;
      cyc(1);
      chk(data, 12'h03C);
      cyc(1);
      rdy = 1'b0;
      chk(valid, 12'h000);
   endtask
   task automatic t_user;
      keep = 4'hC;
      done_c = 1'b1;
      cyc(2);
      chk({umode, dn_oe, gtri, gpd}, 12'h00B);
      chk(pins, 12'h000);
      jen = 1'b1;
      cyc(1);
      chk(pins, 12'h030);
      jen = 1'b0;
      done_c = 1'b0;
      prog_n = 1'b0;
      cyc(8);
      chk({umode, clr, ini_oe, dn_oe}, 12'h007);
      prog_n = 1'b1;
   endtask
   initial
   begin
      #50000;
      n_fail++;
      results();
   end
   initial
   begin
      t_reset();
      t_init();
      t_spi();
      t_user();
      results();
   end
endmodule
`default_nettype wire
